// ---- hbc_boot_seq.v ----
// Boot and configuration sequencer of a four-port hub controller
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "hbc_consts.vh"

module hbc_boot_seq (
    // Clock and reset
    input wire clk_sys,
    input wire resetn,
    // Register port
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata_q,
    // Strap sense inputs
    input wire spi_do_pu,
    input wire spi_clk_pu,
    input wire spi_do_pd,
    input wire spi_clk_pd,
    input wire [2:0] charge_port_select_strap,
    // Serial ROM pins
    output reg spi_ce_n_q,
    output reg spi_ce_oe_q,
    output reg spi_sck_q,
    output reg spi_sck_oe_q,
    output reg spi_io0_o_q,
    output reg spi_io0_oe_q,
    input wire spi_io0_i,
    input wire spi_io1_i,
    // Static board options for the ROM
    input wire spi_dual_sel,
    input wire spi_mode3_sel,
    // System inputs
    input wire pll_locked,
    input wire vbus,
    input wire soft_disconnect,
    input wire usb_configured,
    input wire chg_done,
    input wire [7:0] otp_data,
    input wire [7:0] otp_mask,
    // Status and control outputs
    output reg standby_q,
    output reg pll_run_q,
    output reg port_hiz_q,
    output reg [3:0] ports_en_q,
    output reg [3:0] charge_ports_q,
    output reg [7:0] cfg_word_q,
    output reg ext_rom_q,
    output reg host_mode_q,
    output reg chg_start_q,
    output reg upstream_connect_q,
    output reg suspend_q,
    output reg [9:0] stage_q
);

    // Boot stages, one-hot
    localparam S_PROBE = 10'h001;
    localparam S_LOAD = 10'h002;
    localparam S_STRAP = 10'h004;
    localparam S_HOST = 10'h008;
    localparam S_MERGE = 10'h010;
    localparam S_IDLE = 10'h020;
    localparam S_CHG = 10'h040;
    localparam S_ATTACH = 10'h080;
    localparam S_NORMAL = 10'h100;
    localparam S_SPI = 10'h200;

    // Mode strap: 2'b10 host port, 2'b01 serial ROM, 2'b00 neither
    function [1:0] mode_decode;
        input do_pu, clk_pu, do_pd, clk_pd;
        begin
            mode_decode = {do_pu & clk_pu,
                ~(do_pu | clk_pu | do_pd | clk_pd)};
        end
    endfunction

    // Charge strap level to mask of ports counted from port 1
    function [3:0] charge_decode;
        input [2:0] code;
        begin
            case (code)
                `HBC_STRAP_200K_DN: charge_decode = 4'h0;
                `HBC_STRAP_200K_UP: charge_decode = 4'h1;
                `HBC_STRAP_10K_DN: charge_decode = 4'h3;
                `HBC_STRAP_10K_UP: charge_decode = 4'h7;
                `HBC_STRAP_10R_DN: charge_decode = 4'hf;
                default: charge_decode = 4'h0;
            endcase
        end
    endfunction

    reg [12:0] sync1_q;
    reg [12:0] sync2_q;
    reg [1:0] cap_cnt_q;
    reg cap_done_q;
    reg [1:0] mode_q;
    reg [2:0] chg_code_q;
    reg [7:0] load_cfg_q;
    reg [7:0] host_cfg_q;
    reg host_set_q;
    reg spi_go_q;
    reg spi_busy_q;
    reg spi_done_q;
    reg spi_ph_q;
    reg [2:0] spi_hc_q;
    reg [6:0] spi_bit_q;
    reg [39:0] spi_tx_q;
    reg [31:0] spi_rx_q;
    reg dual_q;
    reg cpol_q;

    wire io1_s = sync2_q[12];
    wire io0_s = sync2_q[11];
    wire vbus_s = sync2_q[10];
    wire sdisc_s = sync2_q[9];
    wire lock_s = sync2_q[8];
    wire [2:0] strap_s = sync2_q[7:5];
    wire [1:0] mode_s = mode_decode(sync2_q[3], sync2_q[2],
        sync2_q[1], sync2_q[0]);
    wire [6:0] tx_bits = dual_q ? `HBC_TX_BITS_DUAL : `HBC_TX_BITS_SGL;
    wire [6:0] all_bits = dual_q ? `HBC_ALL_BITS_DUAL : `HBC_ALL_BITS_SGL;
    wire half_end = (spi_hc_q == `HBC_HALF_LAST);
    wire in_tx = (spi_bit_q < tx_bits);
    wire end_wr = reg_wr & (reg_addr == `HBC_REG_END_CFG);
    wire [7:0] merge_base = host_set_q ? host_cfg_q : load_cfg_q;
    wire [7:0] merge_cfg = (merge_base & ~otp_mask) | (otp_data & otp_mask);

    // Two-flop synchronisers for pins and pin-sensed straps
    always @(posedge clk_sys) begin
        if (!resetn) begin
            sync1_q <= 13'h0000;
            sync2_q <= 13'h0000;
        end else begin
            sync1_q <= {spi_io1_i, spi_io0_i, vbus, soft_disconnect,
                pll_locked, charge_port_select_strap, 1'b0, spi_do_pu,
                spi_clk_pu, spi_do_pd, spi_clk_pd};
            sync2_q <= sync1_q;
        end
    end

    // Strap capture shortly after reset release
    always @(posedge clk_sys) begin
        if (!resetn) begin
            cap_cnt_q <= 2'h0;
            cap_done_q <= 1'b0;
            mode_q <= 2'h0;
            chg_code_q <= 3'h0;
            dual_q <= 1'b0;
            cpol_q <= 1'b0;
        end else if (!cap_done_q) begin
            cap_cnt_q <= cap_cnt_q + 2'h1;
            if (cap_cnt_q == `HBC_CAP_DELAY) begin
                cap_done_q <= 1'b1;
                mode_q <= mode_s;
                chg_code_q <= strap_s;
                dual_q <= spi_dual_sel;
                cpol_q <= spi_mode3_sel;
            end
        end else if (stage_q == S_STRAP) begin
            mode_q <= mode_s;
        end
    end

    // Serial ROM read engine: low half, then high half per clock
    always @(posedge clk_sys) begin
        if (!resetn) begin
            spi_busy_q <= 1'b0;
            spi_done_q <= 1'b0;
            spi_ph_q <= 1'b0;
            spi_hc_q <= 3'h0;
            spi_bit_q <= 7'h00;
            spi_tx_q <= 40'h0;
            spi_rx_q <= 32'h0;
        end else begin
            spi_done_q <= 1'b0;
            if (spi_go_q) begin
                spi_busy_q <= 1'b1;
                spi_ph_q <= 1'b0;
                spi_hc_q <= 3'h0;
                spi_bit_q <= 7'h00;
                // command picks single or dual read
                spi_tx_q <= {dual_q ? `HBC_CMD_DUAL : `HBC_CMD_READ,
                    `HBC_SIG_ADDR, 8'h00};
                spi_rx_q <= 32'h0;
            end else if (spi_busy_q) begin
                spi_hc_q <= half_end ? 3'h0 : spi_hc_q + 3'h1;
                if (half_end && !spi_ph_q) begin
                    spi_ph_q <= 1'b1;
                end else if (half_end) begin
                    spi_ph_q <= 1'b0;
                    spi_bit_q <= spi_bit_q + 7'h01;
                    if (in_tx) begin
                        spi_tx_q <= {spi_tx_q[38:0], 1'b0};
                    end else if (dual_q) begin
                        spi_rx_q <= {spi_rx_q[29:0], io1_s, io0_s};
                    end else begin
                        spi_rx_q <= {spi_rx_q[30:0], io1_s};
                    end
                    if (spi_bit_q == all_bits - 7'h01) begin
                        spi_busy_q <= 1'b0;
                        spi_done_q <= 1'b1;
                    end
                end
            end
        end
    end

    // Boot stage sequencer
    always @(posedge clk_sys) begin
        if (!resetn) begin
            stage_q <= S_PROBE;
            spi_go_q <= 1'b0;
            ext_rom_q <= 1'b0;
            load_cfg_q <= 8'h00;
            cfg_word_q <= 8'h00;
            ports_en_q <= 4'h0;
            charge_ports_q <= 4'h0;
            host_mode_q <= 1'b0;
            chg_start_q <= 1'b0;
            upstream_connect_q <= 1'b0;
            suspend_q <= 1'b0;
        end else begin
            spi_go_q <= 1'b0;
            chg_start_q <= 1'b0;
            case (stage_q)
                S_PROBE: begin
                    if (cap_done_q && !mode_q[0]) begin
                        stage_q <= S_LOAD;
                    end else if (cap_done_q && lock_s) begin
                        spi_go_q <= 1'b1;
                        stage_q <= S_SPI;
                    end
                end
                S_SPI: begin
                    if (spi_done_q) begin
                        ext_rom_q <= (spi_rx_q == `HBC_SIG_WORD);
                        stage_q <= S_LOAD;
                    end
                end
                S_LOAD: begin
                    load_cfg_q <= (`HBC_ROM_DEFAULT & 8'hf0) |
                        {4'h0, charge_decode(chg_code_q)};
                    stage_q <= S_STRAP;
                end
                S_STRAP: begin
                    if (mode_s[1]) begin
                        host_mode_q <= 1'b1;
                        stage_q <= S_HOST;
                    end else begin
                        stage_q <= S_MERGE;
                    end
                end
                S_HOST: begin
                    // only here an end write counts
                    if (end_wr) begin
                        stage_q <= S_MERGE;
                    end
                end
                S_MERGE: begin
                    // OTP bits override the base settings
                    cfg_word_q <= merge_cfg;
                    ports_en_q <= merge_cfg[7:4];
                    charge_ports_q <= merge_cfg[3:0];
                    stage_q <= S_IDLE;
                end
                S_IDLE: begin
                    suspend_q <= ~vbus_s;
                    if (vbus_s && charge_ports_q != 4'h0) begin
                        chg_start_q <= 1'b1;
                        stage_q <= S_CHG;
                    end else if (vbus_s) begin
                        stage_q <= S_ATTACH;
                    end
                end
                S_CHG: begin
                    if (chg_done) begin
                        stage_q <= S_ATTACH;
                    end
                end
                S_ATTACH: begin
                    // connect while VBUS high, no disconnect
                    upstream_connect_q <= vbus_s & ~sdisc_s;
                    if (!vbus_s) begin
                        stage_q <= S_IDLE;
                    end else if (!sdisc_s && usb_configured) begin
                        stage_q <= S_NORMAL;
                    end
                end
                S_NORMAL: begin
                    if (sdisc_s) begin
                        upstream_connect_q <= 1'b0;
                        stage_q <= S_ATTACH;
                    end
                end
                default: begin
                    stage_q <= S_PROBE;
                end
            endcase
        end
    end

    // Host settings register, only open in the host stage
    always @(posedge clk_sys) begin
        if (!resetn) begin
            host_cfg_q <= `HBC_HOST_CFG_RST;
            host_set_q <= 1'b0;
        end else if (reg_wr && reg_addr == `HBC_REG_HOST_CFG &&
            stage_q == S_HOST) begin
            host_cfg_q <= reg_wdata[7:0];
            host_set_q <= 1'b1;
        end
    end

    // Read data, one cycle after the strobe, zero elsewhere
    always @(posedge clk_sys) begin
        if (!resetn) begin
            reg_rdata_q <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `HBC_REG_STAGE: reg_rdata_q <= {6'h00, stage_q};
                `HBC_REG_FLAGS: reg_rdata_q <= {8'h00, ext_rom_q,
                    host_mode_q, host_set_q, suspend_q, charge_ports_q};
                `HBC_REG_CFG: reg_rdata_q <= {8'h00, cfg_word_q};
                `HBC_REG_HOST_CFG: reg_rdata_q <= {8'h00, host_cfg_q};
                default: reg_rdata_q <= 16'h0000;
            endcase
        end else begin
            reg_rdata_q <= 16'h0000;
        end
    end

    // Pin drivers and power state
    always @(posedge clk_sys) begin
        if (!resetn) begin
            standby_q <= 1'b1;
            pll_run_q <= 1'b0;
            port_hiz_q <= 1'b1;
            spi_ce_n_q <= 1'b1;
            spi_ce_oe_q <= 1'b0;
            spi_sck_q <= 1'b0;
            spi_sck_oe_q <= 1'b0;
            spi_io0_o_q <= 1'b0;
            spi_io0_oe_q <= 1'b0;
        end else begin
            standby_q <= 1'b0;
            pll_run_q <= 1'b1;
            port_hiz_q <= 1'b0;
            // Drive ROM pins only in ROM mode so straps stay readable
            spi_ce_oe_q <= mode_q[0] & (stage_q == S_SPI);
            spi_sck_oe_q <= mode_q[0] & (stage_q == S_SPI);
            spi_ce_n_q <= ~spi_busy_q;
            spi_sck_q <= spi_busy_q ? spi_ph_q : cpol_q;
            spi_io0_o_q <= spi_busy_q & spi_tx_q[39];
            // release data line during dual read
            spi_io0_oe_q <= spi_busy_q & (in_tx | ~dual_q);
        end
    end
endmodule
`default_nettype wire

// ---- hbc_boot_seq_sva.sv ----
// Port-level assertions for the hub boot sequencer
`timescale 1ns/100ps
`default_nettype none
module hbc_boot_seq_sva (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    // Serial ROM pins
    input wire logic spi_ce_n_q,
    input wire logic spi_ce_oe_q,
    input wire logic spi_sck_q,
    // Status outputs
    input wire logic standby_q,
    input wire logic pll_run_q,
    input wire logic port_hiz_q,
    input wire logic [3:0] ports_en_q,
    input wire logic [3:0] charge_ports_q,
    input wire logic chg_start_q,
    input wire logic upstream_connect_q,
    input wire logic suspend_q,
    input wire logic [9:0] stage_q
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // Steps of the boot and of the ROM clock
    sequence s_release;
        resetn && !$past(resetn);
    endsequence
    sequence s_end_cfg;
        stage_q == 10'h008 && reg_wr && reg_addr == 8'hff;
    endsequence
    sequence s_half;
        $changed(spi_sck_q) && !spi_ce_n_q;
    endsequence

    property p_reset_state;
        s_release |-> standby_q && !pll_run_q && port_hiz_q &&
            ports_en_q == 4'h0 && stage_q == 10'h001;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("standby state wrong at release");
    // hub mode one edge after release
    property p_wake;
        s_release |=> !standby_q && pll_run_q && !port_hiz_q;
    endproperty
    a_wake: assert property (p_wake)
        else $error("hub mode not entered");
    property p_hiz;
        port_hiz_q |-> ports_en_q == 4'h0 && !upstream_connect_q;
    endproperty
    a_hiz: assert property (p_hiz)
        else $error("ports active while high impedance");
    // host stage waits for end write
    property p_host_wait;
        stage_q == 10'h008 && !(reg_wr && reg_addr == 8'hff)
            |=> stage_q == 10'h008;
    endproperty
    a_host_wait: assert property (p_host_wait)
        else $error("host stage left early");
    // end write goes through merge to idle
    property p_end_cfg;
        s_end_cfg |=> stage_q == 10'h010 ##1 stage_q == 10'h020;
    endproperty
    a_end_cfg: assert property (p_end_cfg)
        else $error("end of setup not followed");
    // chip select only for the ROM read
    property p_ce_rom;
        !spi_ce_n_q |-> $past(stage_q) == 10'h200 && spi_ce_oe_q;
    endproperty
    a_ce_rom: assert property (p_ce_rom)
        else $error("chip select outside ROM read");
    // each clock phase lasts four cycles
    property p_sck_half;
        s_half |=> $stable(spi_sck_q)[*3];
    endproperty
    a_sck_half: assert property (p_sck_half)
        else $error("ROM clock phase too short");
    // charger start only with charging ports
    property p_chg;
        chg_start_q |-> charge_ports_q != 4'h0 ##1 !chg_start_q;
    endproperty
    a_chg: assert property (p_chg)
        else $error("bad charger start pulse");
    property p_suspend;
        suspend_q |-> stage_q == 10'h020;
    endproperty
    a_suspend: assert property (p_suspend)
        else $error("suspend outside idle");
    // connect only in attach or normal
    property p_connect;
        upstream_connect_q |-> stage_q[7] || stage_q[8];
    endproperty
    a_connect: assert property (p_connect)
        else $error("connect outside attach");
    property p_onehot;
        $onehot(stage_q);
    endproperty
    a_onehot: assert property (p_onehot)
        else $error("stage code not one-hot");
endmodule
bind hbc_boot_seq hbc_boot_seq_sva u_sva (.*);
`default_nettype wire

// ---- hbc_consts.vh ----
// Constants for the hub boot and configuration sequencer
`ifndef HBC_CONSTS_VH
`define HBC_CONSTS_VH

// System clock rate and serial ROM clock half period
`define HBC_CLK_MHZ 100
`define HBC_SPI_HALF_NS 40
`define HBC_SPI_HALF_CYC ((`HBC_SPI_HALF_NS * `HBC_CLK_MHZ) / 1000)
`define HBC_HALF_LAST 3'h3

// Serial ROM probe
`define HBC_SIG_WORD 32'h32444655
`define HBC_SIG_ADDR 24'hfffa
`define HBC_CMD_READ 8'h03
`define HBC_CMD_DUAL 8'h3b
`define HBC_TX_BITS_SGL 7'h20
`define HBC_TX_BITS_DUAL 7'h28
`define HBC_ALL_BITS_SGL 7'h40
`define HBC_ALL_BITS_DUAL 7'h38

// Five-level charge strap codes from the pin sense front end
`define HBC_STRAP_200K_DN 3'h0
`define HBC_STRAP_200K_UP 3'h1
`define HBC_STRAP_10K_DN 3'h2
`define HBC_STRAP_10K_UP 3'h3
`define HBC_STRAP_10R_DN 3'h4

// Register offsets
`define HBC_REG_STAGE 8'h00
`define HBC_REG_FLAGS 8'h02
`define HBC_REG_CFG 8'h04
`define HBC_REG_HOST_CFG 8'h10
`define HBC_REG_END_CFG 8'hff

// Reset and default values
`define HBC_ROM_DEFAULT 8'hf0
`define HBC_HOST_CFG_RST 8'h00
`define HBC_CAP_DELAY 2'h2

`endif

// ---- hbc_flash_model.sv ----
// Serial flash holding the boot signature
`timescale 1ns/100ps
`default_nettype none
module hbc_flash_model (
    // Flash pins
    input wire logic sck,
    input wire logic ce_n,
    input wire logic mosi,
    output logic miso,
    output logic io0_out,
    // Scenario controls
    input wire logic dual,
    input wire logic bad
);
    logic [63:0] sh;
    logic [31:0] dat;
    logic [31:0] w;
    logic [31:0] hd;
    int n;
    int hdr;
    initial begin
        miso = 1'b0;
        io0_out = 1'b0;
        n = 0;
    end
    // dual reads add eight dummy clocks
    assign hdr = dual ? 40 : 32;
    assign hd = dual ? sh[39:8] : sh[31:0];
    // sample on rising clock at any rate, both idle levels
    always @(posedge sck or posedge ce_n)
        if (ce_n) begin
            n <= 0;
        end else begin
            sh <= {sh[62:0], mosi};
            n <= n + 1;
        end
    // answer on falling clock, released lines toggle
    always @(negedge sck or posedge ce_n)
        if (ce_n || n < hdr) begin
            miso <= ~miso;
            io0_out <= ~io0_out;
        end else begin
            // Signature "2DFU" only for a proper command at 0xfffa
            w = (n != hdr) ? dat : (!bad && hd ==
                {dual ? 8'h3b : 8'h03, 24'h00fffa}) ? 32'h32444655 : 32'h0;
            miso <= w[31];
            io0_out <= dual ? w[30] : ~io0_out;
            dat <= dual ? {w[29:0], 2'b00} : {w[30:0], 1'b0};
        end
endmodule
`default_nettype wire

// ---- tb_hbc_boot_seq.sv ----
// Self-checking bench for the hub boot sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
    n_mismatch++; $display("[ERR] %s expected %h seen %h", n, e, g); end end
module tb_hbc_boot_seq;
    logic clk_sys, resetn, reg_wr, reg_rd, bad;
    logic [7:0] reg_addr, otp_data, otp_mask;
    logic [15:0] reg_wdata;
    logic spi_do_pu, spi_clk_pu, spi_do_pd, spi_clk_pd;
    logic [2:0] charge_port_select_strap;
    logic spi_dual_sel, spi_mode3_sel, pll_locked, vbus;
    logic soft_disconnect, usb_configured, chg_done;
    wire [15:0] reg_rdata_q;
    wire spi_ce_n_q, spi_ce_oe_q, spi_sck_q, spi_sck_oe_q;
    wire spi_io0_o_q, spi_io0_oe_q, spi_io0_i, spi_io1_i, fl_io0;
    wire standby_q, pll_run_q, port_hiz_q, ext_rom_q, host_mode_q;
    wire chg_start_q, upstream_connect_q, suspend_q;
    wire [3:0] ports_en_q, charge_ports_q;
    wire [7:0] cfg_word_q;
    wire [9:0] stage_q;
    int n_mismatch = 0;
    int total_checks = 0;
    logic [3:0] chg_tab [5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hf};

    hbc_boot_seq uut (.*);
    hbc_flash_model fm (.sck(spi_sck_q), .ce_n(spi_ce_n_q | ~spi_ce_oe_q),
        .mosi(spi_io0_o_q), .miso(spi_io1_i), .io0_out(fl_io0),
        .dual(spi_dual_sel), .bad(bad));
    // Shared data line: whoever enables drives it
    assign spi_io0_i = spi_io0_oe_q ? spi_io0_o_q : fl_io0;

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Reset with new straps, check standby, then release
    task automatic boot(input logic [3:0] p, input logic [2:0] st,
            input logic [1:0] opt, input logic b);
        @(posedge clk_sys);
        resetn <= 1'b0;
        {spi_do_pu, spi_clk_pu, spi_do_pd, spi_clk_pd} <= p;
        charge_port_select_strap <= st;
        {spi_dual_sel, spi_mode3_sel} <= opt;
        bad <= b;
        {vbus, soft_disconnect, usb_configured, chg_done} <= 4'h0;
        repeat (20) @(posedge clk_sys);
        #1;
        `CHK("standby", 1'b1, standby_q)
        `CHK("pll", 1'b0, pll_run_q)
        `CHK("ports", 4'h0, ports_en_q)
        `CHK("cfg", 8'h00, cfg_word_q)
        `CHK("connect", 1'b0, upstream_connect_q)
        `CHK("stage", 10'h001, stage_q)
        @(posedge clk_sys) resetn <= 1'b1;
    endtask

    task automatic wait_st(input logic [9:0] s);
        int i;
        i = 0;
        do begin
            @(posedge clk_sys);
            #1;
            i++;
        end while (stage_q !== s && i < 3000);
        `CHK("stage", s, stage_q)
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys) reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys) reg_rd <= 1'b0;
        #1;
        `CHK("rdata", e, reg_rdata_q)
    endtask

    // Cut a hang short
    initial begin
        #400000;
        n_mismatch++;
        give_verdict;
    end

    initial begin
        {resetn, reg_wr, reg_rd, bad, reg_addr, reg_wdata} = '0;
        {otp_data, otp_mask, spi_dual_sel, spi_mode3_sel} = '0;
        {spi_do_pu, spi_clk_pu, spi_do_pd, spi_clk_pd} = 4'h0;
        charge_port_select_strap = 3'h0;
        {vbus, soft_disconnect, usb_configured, chg_done} = 4'h0;
        pll_locked = 1'b1;
        // Every strap level, mixed pulls so no ROM probe
        for (int k = 0; k < 5; k++) begin
            boot(4'h8, k[2:0], 2'b00, 1'b0);
            wait_st(10'h020);
            `CHK("charge", chg_tab[k], charge_ports_q)
            `CHK("cfg", {4'hf, chg_tab[k]}, cfg_word_q)
            `CHK("ext_rom", 1'b0, ext_rom_q)
            @(posedge clk_sys);
            #1;
            `CHK("suspend", 1'b1, suspend_q)
        end
        // Single-bit read, good signature, then the stage walk from idle through charge and attach to normal
        boot(4'h0, 3'h1, 2'b00, 1'b0);
        wait_st(10'h200);
        wait_st(10'h020);
        `CHK("ext_rom", 1'b1, ext_rom_q)
        wr(8'hff, 16'h0000);
        rd(8'h00, 16'h0020);
        rd(8'h04, 16'h00f1);
        rd(8'h20, 16'h0000);
        @(posedge clk_sys) vbus <= 1'b1;
        wait_st(10'h040);
        `CHK("chg_start", 1'b1, chg_start_q)
        @(posedge clk_sys) chg_done <= 1'b1;
        wait_st(10'h080);
        @(posedge clk_sys);
        #1;
        `CHK("connect", 1'b1, upstream_connect_q)
        @(posedge clk_sys) usb_configured <= 1'b1;
        wait_st(10'h100);
        `CHK("ports", 4'hf, ports_en_q)
        wr(8'hff, 16'h0000);
        wait_st(10'h100);
        @(posedge clk_sys) soft_disconnect <= 1'b1;
        wait_st(10'h080);
        `CHK("connect", 1'b0, upstream_connect_q)
        @(posedge clk_sys) soft_disconnect <= 1'b0;
        wait_st(10'h100);
        // Dual read in mode 3, no charging: straight to attach
        boot(4'h0, 3'h0, 2'b11, 1'b0);
        wait_st(10'h020);
        `CHK("ext_rom", 1'b1, ext_rom_q)
        @(posedge clk_sys) vbus <= 1'b1;
        wait_st(10'h080);
        @(posedge clk_sys) vbus <= 1'b0;
        wait_st(10'h020);
        // Wrong signature falls back to internal ROM
        boot(4'h0, 3'h4, 2'b01, 1'b1);
        wait_st(10'h020);
        `CHK("ext_rom", 1'b0, ext_rom_q)
        // Host setup with one-time data over the low nibble
        @(posedge clk_sys);
        otp_mask <= 8'h0f;
        otp_data <= 8'h03;
        boot(4'hc, 3'h2, 2'b00, 1'b0);
        wait_st(10'h008);
        `CHK("host_mode", 1'b1, host_mode_q)
        wr(8'h10, 16'h005a);
        rd(8'h10, 16'h005a);
        wait_st(10'h008);
        wr(8'hff, 16'h0000);
        wait_st(10'h020);
        `CHK("cfg", 8'h53, cfg_word_q)
        give_verdict;
    end
endmodule
`default_nettype wire
